// ==== hw/aec_cfg.svh ====
/*
  constants of the event counter: register indexes, field bits,
  reset values and prescaler taps. assumes byte address = 4*index.
*/
// Contract
// - edge select 00 counts low pin falling edges
// - clock select 00 takes low pin events
// - upper overflow flag bit 7 shows overflow
// - lower overflow flag bit 6 shows overflow
// - split bit 0 chains, 1 splits channels
// - upper enable bit 3 gates upper events
// - lower enable bit 2 gates lower events
// - upper release bit 1 low holds upper clear
// - lower release bit 0 low holds lower clear
// - upper count is read-only high byte
// - lower count is read-only low byte
// - chained upper steps on lower overflow
// - power save counts but freezes flags
`ifndef AEC_CFG_SVH
`define AEC_CFG_SVH

// ----------------------------------------
// register indexes (byte address = 4*index)
// ----------------------------------------
`define AEC_IDX_EDGE     16'hFF92
`define AEC_IDX_CLKC     16'hFF94
`define AEC_IDX_CSR      16'hFF95
`define AEC_IDX_UCNT     16'hFF96
`define AEC_IDX_LCNT     16'hFF97
`define AEC_IDX_ISTAT    16'hFF98
`define AEC_IDX_IMASK    16'hFF99

// ----------------------------------------
// field positions
// ----------------------------------------
`define AEC_SEL_HI       5
`define AEC_SEL_LO       4
`define AEC_B_UOVF       7
`define AEC_B_LOVF       6
`define AEC_B_SPLIT      4
`define AEC_B_UEN        3
`define AEC_B_LEN        2
`define AEC_B_UREL       1
`define AEC_B_LREL       0
`define AEC_I_LOVF       0
`define AEC_I_UOVF       1

// ----------------------------------------
// reset values and prescaler tap masks
// ----------------------------------------
`define AEC_RST_REG      8'h00
`define AEC_CNT_FULL     8'hFF
`define AEC_TAP_1        8'h03
`define AEC_TAP_2        8'h0F
`define AEC_TAP_3        8'h3F

`endif

// ==== hw/aec_pkg.sv ====
/*
  types of the event counter.
  assumes aec_cfg.svh holds the numbers.
*/
package aec_pkg;
  // edge sensing of the low event pin
  typedef enum logic [1:0] {
    AEC_EDGE_FALL = 2'h0,
    AEC_EDGE_RISE = 2'h1,
    AEC_EDGE_BOTH = 2'h2,
    AEC_EDGE_ALSO = 2'h3
  } aec_edge_t;
  // axi response codes
  typedef enum logic [1:0] {
    AEC_RESP_OKAY   = 2'h0,
    AEC_RESP_SLVERR = 2'h2
  } aec_resp_t;
endpackage

// ==== hw/aec_sync.sv ====
/*
  two-flop synchroniser per bit.
  assumes inputs are asynchronous levels.
*/
`timescale 1ns/10ps
module aec_sync import aec_pkg::*; #(
  parameter int W = 2
) (
  input  wire logic         clk,    // system clock
  input  wire logic         nrst,   // async reset, low
  input  wire logic         ce,     // clock enable
  input  wire logic [W-1:0] d,      // raw inputs
  output logic      [W-1:0] q       // synchronised
);
  logic [W-1:0] meta;               // first stage, read by q only
  // one generate loop, one pair of flops per bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        meta[i] <= 1'b0;
        q[i]    <= 1'b0;
      end else if (ce) begin
        meta[i] <= d[i];
        q[i]    <= meta[i];
      end
    end
  end
endmodule

// ==== hw/aec_chan.sv ====
/*
  one 8-bit up-counter channel with hold-clear and step.
  assumes step is a one-cycle pulse already gated.
*/
`timescale 1ns/10ps
`include "aec_cfg.svh"
module aec_chan import aec_pkg::*; #(
  parameter int W = 8
) (
  input  wire logic         clk,    // system clock
  input  wire logic         nrst,   // async reset, low
  input  wire logic         ce,     // clock enable
  input  wire logic         hold,   // clear while high
  input  wire logic         step,   // count one event
  output logic      [W-1:0] count,  // current count
  output logic              ovf     // wrap pulse
);
  logic [W-1:0] next_count;         // incremented value
  // wrap happens when stepping from all ones
  assign ovf        = step && !hold && (count == {W{1'b1}});
  assign next_count = count + {{(W-1){1'b0}}, 1'b1};
  // hold wins over stepping
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else if (ce) begin
      if (hold) begin
        count <= '0;
      end else if (step) begin
        count <= next_count;
      end
    end
  end
endmodule

// ==== hw/aec_top.sv ====
/*
  async event counter: two 8-bit counters, chained or split,
  low pin edge/clock select, overflow flags, irq, axi4-lite.
  assumes event pins are asynchronous and slower than CLK/4;
  assumes one axi master, one write and one read at a time.
*/
`timescale 1ns/10ps
`include "aec_cfg.svh"
module aec_top import aec_pkg::*; #(
  parameter int AW = 18
) (
  // clock, reset, enable
  input  wire logic          CLK,
  input  wire logic          NRST,
  input  wire logic          CE,
  // event pins and power state
  input  wire logic          LOW_EVENT_PIN,
  input  wire logic          HIGH_EVENT_PIN,
  input  wire logic          POWER_SAVE,
  // axi write address
  input  wire logic [AW-1:0] AWADDR,
  input  wire logic          AWVALID,
  output logic               AWREADY,
  // axi write data
  input  wire logic [31:0]   WDATA,
  input  wire logic [3:0]    WSTRB,
  input  wire logic          WVALID,
  output logic               WREADY,
  // axi write response
  output logic [1:0]         BRESP,
  output logic               BVALID,
  input  wire logic          BREADY,
  // axi read address
  input  wire logic [AW-1:0] ARADDR,
  input  wire logic          ARVALID,
  output logic               ARREADY,
  // axi read data
  output logic [31:0]        RDATA,
  output logic [1:0]         RRESP,
  output logic               RVALID,
  input  wire logic          RREADY,
  // interrupt
  output logic               IRQ
);

  // ----------------------------------------
  // address map
  // ----------------------------------------
  localparam logic [AW-1:0] A_EDGE  = AW'({`AEC_IDX_EDGE, 2'b00});
  localparam logic [AW-1:0] A_CLKC  = AW'({`AEC_IDX_CLKC, 2'b00});
  localparam logic [AW-1:0] A_CSR   = AW'({`AEC_IDX_CSR, 2'b00});
  localparam logic [AW-1:0] A_UCNT  = AW'({`AEC_IDX_UCNT, 2'b00});
  localparam logic [AW-1:0] A_LCNT  = AW'({`AEC_IDX_LCNT, 2'b00});
  localparam logic [AW-1:0] A_ISTAT = AW'({`AEC_IDX_ISTAT, 2'b00});
  localparam logic [AW-1:0] A_IMASK = AW'({`AEC_IDX_IMASK, 2'b00});

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  logic [7:0]    input_edge_select;      // edge select, rw
  logic [7:0]    counter_clock_control;  // clock select, rw
  logic [5:0]    csr_ctrl;               // csr bits 5..0
  logic          upper_overflow_flag;    // csr bit 7
  logic          lower_overflow_flag;    // csr bit 6
  logic          upper_armed;            // flag read as one
  logic          lower_armed;            // flag read as one
  logic [1:0]    irq_status;             // sticky events
  logic [1:0]    irq_mask;               // one enables

  // ----------------------------------------
  // write channel state
  // ----------------------------------------
  logic [AW-1:0] aw_addr;                // held address
  logic          aw_full;                // address held
  logic [7:0]    w_byte;                 // held low byte
  logic          w_lane;                 // low lane strobe
  logic          w_full;                 // data held

  // ----------------------------------------
  // event path wires
  // ----------------------------------------
  logic [1:0]    pin_sync;               // synced pins
  logic [1:0]    pin_prev;               // last synced
  logic [7:0]    presc;                  // free prescaler
  logic [7:0]    upper_count;            // upper channel
  logic [7:0]    lower_count;            // lower channel
  logic          upper_ovf;              // upper wrap
  logic          lower_ovf;              // lower wrap

  // ----------------------------------------
  // control field decode
  // ----------------------------------------
  aec_edge_t     edge_mode;
  wire           low_edge_sel_hi     = input_edge_select[`AEC_SEL_HI];
  wire           low_edge_sel_lo     = input_edge_select[`AEC_SEL_LO];
  wire           low_clk_sel_hi      = counter_clock_control[`AEC_SEL_HI];
  wire           low_clk_sel_lo      = counter_clock_control[`AEC_SEL_LO];
  wire           split_channel_mode  = csr_ctrl[`AEC_B_SPLIT];
  wire           upper_count_enable  = csr_ctrl[`AEC_B_UEN];
  wire           lower_count_enable  = csr_ctrl[`AEC_B_LEN];
  wire           upper_reset_release = csr_ctrl[`AEC_B_UREL];
  wire           lower_reset_release = csr_ctrl[`AEC_B_LREL];
  assign edge_mode = aec_edge_t'({low_edge_sel_hi, low_edge_sel_lo});

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // pins are asynchronous; nothing reads them before two flops
  aec_sync #(
    .W (2)
  ) u_sync (
    .clk  (CLK),
    .nrst (NRST),
    .ce   (CE),
    .d    ({HIGH_EVENT_PIN, LOW_EVENT_PIN}),
    .q    (pin_sync)
  );

  // previous sample for edge detection, plus free prescaler
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pin_prev <= 2'h0;
      presc    <= 8'h00;
    end else if (CE) begin
      pin_prev <= pin_sync;
      presc    <= presc + 8'h01;
    end
  end

  // ----------------------------------------
  // edge detection and source select
  // ----------------------------------------
  wire low_fall  = pin_prev[0] && !pin_sync[0];
  wire low_rise  = !pin_prev[0] && pin_sync[0];
  wire high_fall = pin_prev[1] && !pin_sync[1];
  // 00 falls, 01 rises, 1x both edges
  wire low_pin_evt = (edge_mode == AEC_EDGE_FALL) ? low_fall :
                     (edge_mode == AEC_EDGE_RISE) ? low_rise :
                     (low_fall || low_rise);
  // prescaler taps: each fires one cycle per period
  wire tap1 = (presc & `AEC_TAP_1) == `AEC_TAP_1;
  wire tap2 = (presc & `AEC_TAP_2) == `AEC_TAP_2;
  wire tap3 = (presc & `AEC_TAP_3) == `AEC_TAP_3;
  wire [1:0] clk_sel = {low_clk_sel_hi, low_clk_sel_lo};
  // 00 takes pin events, others an internal tick
  wire low_src = (clk_sel == 2'h0) ? low_pin_evt :
                 (clk_sel == 2'h1) ? tap1 :
                 (clk_sel == 2'h2) ? tap2 : tap3;

  // ----------------------------------------
  // counter gating
  // ----------------------------------------
  // control bits act on the cycle of a sampled event, so a
  // change never splits an increment in half
  wire low_step = low_src && lower_count_enable;
  wire low_hold = !lower_reset_release;
  // chained: upper follows lower wraps; split: own pin
  wire up_src   = split_channel_mode ? high_fall : lower_ovf;
  wire up_step  = up_src && upper_count_enable;
  wire up_hold  = !upper_reset_release;

  // lower byte of the chained count
  aec_chan #(
    .W (8)
  ) u_lower (
    .clk   (CLK),
    .nrst  (NRST),
    .ce    (CE),
    .hold  (low_hold),
    .step  (low_step),
    .count (lower_count),
    .ovf   (lower_ovf)
  );

  // upper byte of the chained count
  aec_chan #(
    .W (8)
  ) u_upper (
    .clk   (CLK),
    .nrst  (NRST),
    .ce    (CE),
    .hold  (up_hold),
    .step  (up_step),
    .count (upper_count),
    .ovf   (upper_ovf)
  );

  // ----------------------------------------
  // flag events
  // ----------------------------------------
  // power save keeps counting but leaves flags and irq alone
  wire set_lovf = lower_ovf && !POWER_SAVE;
  wire set_uovf = upper_ovf && !POWER_SAVE;

  // ----------------------------------------
  // axi write decode
  // ----------------------------------------
  wire aw_take   = AWVALID && AWREADY;
  wire w_take    = WVALID && WREADY;
  wire do_write  = aw_full && w_full && !BVALID;
  wire wr_edge   = do_write && w_lane && (aw_addr == A_EDGE);
  wire wr_clkc   = do_write && w_lane && (aw_addr == A_CLKC);
  wire wr_csr    = do_write && w_lane && (aw_addr == A_CSR);
  wire wr_istat  = do_write && w_lane && (aw_addr == A_ISTAT);
  wire wr_imask  = do_write && w_lane && (aw_addr == A_IMASK);
  // counters are mapped but ignore writes
  wire wr_mapped = (aw_addr == A_EDGE) || (aw_addr == A_CLKC) ||
                   (aw_addr == A_CSR) || (aw_addr == A_UCNT) ||
                   (aw_addr == A_LCNT) || (aw_addr == A_ISTAT) ||
                   (aw_addr == A_IMASK);
  wire b_done    = BVALID && BREADY;

  // ----------------------------------------
  // axi read decode
  // ----------------------------------------
  wire ar_take  = ARVALID && ARREADY;
  wire rd_csr   = ar_take && (ARADDR == A_CSR);
  wire [7:0] csr_view = {upper_overflow_flag, lower_overflow_flag,
                         2'h0, csr_ctrl[3:0]};
  // bits 5..4 of csr: bit 4 split; bit 5 spare storage
  wire [7:0] csr_read = {csr_view[7:6], csr_ctrl[5:4], csr_view[3:0]};
  wire rd_mapped = (ARADDR == A_EDGE) || (ARADDR == A_CLKC) ||
                   (ARADDR == A_CSR) || (ARADDR == A_UCNT) ||
                   (ARADDR == A_LCNT) || (ARADDR == A_ISTAT) ||
                   (ARADDR == A_IMASK);
  wire [7:0] rd_byte = (ARADDR == A_EDGE)  ? input_edge_select :
                       (ARADDR == A_CLKC)  ? counter_clock_control :
                       (ARADDR == A_CSR)   ? csr_read :
                       (ARADDR == A_UCNT)  ? upper_count :
                       (ARADDR == A_LCNT)  ? lower_count :
                       (ARADDR == A_ISTAT) ? {6'h00, irq_status} :
                       (ARADDR == A_IMASK) ? {6'h00, irq_mask} :
                       8'h00;
  wire r_done = RVALID && RREADY;

  // ----------------------------------------
  // overflow flag next values
  // ----------------------------------------
  // clear needs a prior read of one and a written zero;
  // an overflow in the same cycle still wins
  wire clr_u = wr_csr && upper_armed && !w_byte[`AEC_B_UOVF];
  wire clr_l = wr_csr && lower_armed && !w_byte[`AEC_B_LOVF];
  wire next_upper_flag = set_uovf || (upper_overflow_flag && !clr_u);
  wire next_lower_flag = set_lovf || (lower_overflow_flag && !clr_l);
  // arming survives until a clearing write, even one that a same-cycle overflow overrides
  wire next_upper_armed = (rd_csr && upper_overflow_flag) ||
                          (upper_armed && !clr_u);
  wire next_lower_armed = (rd_csr && lower_overflow_flag) ||
                          (lower_armed && !clr_l);

  // ----------------------------------------
  // interrupt status next value
  // ----------------------------------------
  wire [1:0] irq_set = {set_uovf, set_lovf};
  wire [1:0] irq_clr = wr_istat ? w_byte[1:0] : 2'h0;
  wire [1:0] next_irq_status = irq_set | (irq_status & ~irq_clr);
  wire next_irq = |(next_irq_status & irq_mask);

  // control registers, written over the low lane only
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      input_edge_select     <= `AEC_RST_REG;
      counter_clock_control <= `AEC_RST_REG;
      csr_ctrl              <= 6'h00;
      irq_mask              <= 2'h0;
    end else if (CE) begin
      if (wr_edge) begin
        input_edge_select <= w_byte;
      end
      if (wr_clkc) begin
        counter_clock_control <= w_byte;
      end
      if (wr_csr) begin
        csr_ctrl <= w_byte[5:0];
      end
      if (wr_imask) begin
        irq_mask <= w_byte[1:0];
      end
    end
  end

  // overflow flags and interrupt state
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      upper_overflow_flag <= 1'b0;
      lower_overflow_flag <= 1'b0;
      upper_armed         <= 1'b0;
      lower_armed         <= 1'b0;
      irq_status          <= 2'h0;
      IRQ                 <= 1'b0;
    end else if (CE) begin
      upper_overflow_flag <= next_upper_flag;
      lower_overflow_flag <= next_lower_flag;
      upper_armed         <= next_upper_armed;
      lower_armed         <= next_lower_armed;
      irq_status          <= next_irq_status;
      IRQ                 <= next_irq;
    end
  end

  // ----------------------------------------
  // axi write channel
  // ----------------------------------------
  // address and data may land in either order; readies stay low
  // until the response is taken, so only one write is in flight
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      AWREADY <= 1'b1;
      WREADY  <= 1'b1;
      aw_addr <= '0;
      aw_full <= 1'b0;
      w_byte  <= 8'h00;
      w_lane  <= 1'b0;
      w_full  <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= AEC_RESP_OKAY;
    end else if (CE) begin
      if (aw_take) begin
        aw_addr <= AWADDR;
        aw_full <= 1'b1;
        AWREADY <= 1'b0;
      end
      if (w_take) begin
        w_byte <= WDATA[7:0];
        w_lane <= WSTRB[0];
        w_full <= 1'b1;
        WREADY <= 1'b0;
      end
      if (do_write) begin
        aw_full <= 1'b0;
        w_full  <= 1'b0;
        BVALID  <= 1'b1;
        BRESP   <= wr_mapped ? AEC_RESP_OKAY : AEC_RESP_SLVERR;
      end
      if (b_done) begin
        BVALID  <= 1'b0;
        AWREADY <= 1'b1;
        WREADY  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // axi read channel
  // ----------------------------------------
  // data is captured at the address handshake, one cycle latency
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
      RDATA   <= 32'h00000000;
      RRESP   <= AEC_RESP_OKAY;
    end else if (CE) begin
      if (ar_take) begin
        ARREADY <= 1'b0;
        RVALID  <= 1'b1;
        RDATA   <= {24'h000000, rd_byte};
        RRESP   <= rd_mapped ? AEC_RESP_OKAY : AEC_RESP_SLVERR;
      end
      if (r_done) begin
        RVALID  <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end

  // a counter read while counting may tear between bytes; software
  // stops both enables first, the logic does not latch a snapshot
  // chained mode counts right only if upper enable is on at every lower wrap

endmodule

// ==== tb/aec_top_properties.sv ====
/*
  port checker of the event counter: bus answers and irq causes.
  assumes binding into aec_top, one clock domain.
*/
`timescale 1ns/10ps
module aec_top_properties #(
  parameter int AW = 18
) (
  // clock, reset, enable
  input logic          CLK,
  input logic          NRST,
  input logic          CE,
  // event pins and power state
  input logic          LOW_EVENT_PIN,
  input logic          HIGH_EVENT_PIN,
  input logic          POWER_SAVE,
  // write channels
  input logic [AW-1:0] AWADDR,
  input logic          AWVALID,
  input logic          AWREADY,
  input logic [31:0]   WDATA,
  input logic [3:0]    WSTRB,
  input logic          WVALID,
  input logic          WREADY,
  input logic [1:0]    BRESP,
  input logic          BVALID,
  input logic          BREADY,
  // read channels
  input logic [AW-1:0] ARADDR,
  input logic          ARVALID,
  input logic          ARREADY,
  input logic [31:0]   RDATA,
  input logic [1:0]    RRESP,
  input logic          RVALID,
  input logic          RREADY,
  // interrupt
  input logic          IRQ
);
  // ----------------------------------------
  // one domain, so one default clock
  // ----------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);

  // answers hold until the master takes them
  bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped before taken");
  rdata_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped before taken");
  // write answered two edges after address and data
  write_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY && CE ##1 CE
    |=> BVALID) else $error("write response late");
  read_answer_a: assert property (ARVALID && ARREADY && CE |=> RVALID)
    else $error("read data late");
  // no new request while one is open
  write_busy_a: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while response open");
  read_busy_a: assert property (RVALID |-> !ARREADY)
    else $error("read taken while data open");
  // registers are one byte wide
  byte_read_a: assert property (RVALID |-> RDATA[31:8] == 24'h0)
    else $error("read data above byte");
  // flags never set in power save; a mask write may raise irq
  irq_cause_a: assert property ($rose(IRQ) |-> !$past(POWER_SAVE) || $past(BVALID))
    else $error("irq rose without cause");
  // only a write of software takes irq down; a status clear drops it
  // on the very edge that raises the response
  irq_clear_a: assert property ($fell(IRQ) |-> BVALID || $past(BVALID))
    else $error("irq fell without write");
endmodule

bind aec_top aec_top_properties #(.AW(AW)) aec_top_properties_i (
  .CLK(CLK), .NRST(NRST), .CE(CE), .LOW_EVENT_PIN(LOW_EVENT_PIN),
  .HIGH_EVENT_PIN(HIGH_EVENT_PIN), .POWER_SAVE(POWER_SAVE),
  .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
  .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
  .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
  .RREADY(RREADY), .IRQ(IRQ)
);

// ==== tb/aec_event_src.sv ====
/*
  outside event source driving both event pins.
  assumes pins idle high and events are falling edges.
*/
`timescale 1ns/10ps
module aec_event_src (
  // event pins, idle high
  output logic low_pin,
  output logic high_pin
);
  initial begin
    low_pin = 1'b1;
    high_pin = 1'b1;
  end
  // n pulses, each level half ns wide; offset keeps edges off CLK
  // a half under 80 ns would break the 2-cycle width limit
  task automatic pulse(input bit hi, input int n, input int half);
    #7;
    for (int i = 0; i < n; i++) begin
      if (hi) high_pin = 1'b0; else low_pin = 1'b0;
      #(half);
      if (hi) high_pin = 1'b1; else low_pin = 1'b1;
      #(half);
    end
  endtask
endmodule

// ==== tb/async_event_counter_tb.sv ====
/*
  self-checking bench of the event counter over axi4-lite.
  assumes aec_top, aec_event_src and the bound checker.
*/
`timescale 1ns/10ps
`include "aec_cfg.svh"
module async_event_counter_tb import aec_pkg::*;;
  logic        clk, nrst, ce, ps, lpin, hpin, irq;      // clock, reset, pins
  logic [17:0] awaddr, araddr;                          // byte addresses
  logic [31:0] wdata, rdata;                            // data words
  logic [3:0]  wstrb;                                   // byte lanes
  logic [1:0]  bresp, rresp;                            // answers
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          miscompares, checked;                    // tallies

  aec_top #(.AW(18)) aec_top_i (
    .CLK(clk), .NRST(nrst), .CE(ce), .LOW_EVENT_PIN(lpin), .HIGH_EVENT_PIN(hpin),
    .POWER_SAVE(ps), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .IRQ(irq)
  );
  aec_event_src aec_event_src_i (.low_pin(lpin), .high_pin(hpin));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // compare and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [15:0] idx, input logic [7:0] d,
                    input logic [1:0] r = AEC_RESP_OKAY);
    logic a, w;
    a = 1'b1;
    w = 1'b1;
    @(posedge clk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    {awvalid, wvalid, bready} <= 3'h7;
    while (a || w) begin
      @(posedge clk);
      if (awready === 1'b1) a = 1'b0;
      if (wready === 1'b1) w = 1'b0;
      awvalid <= a;
      wvalid <= w;
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, r});
  endtask
  // read: one word, data and code taken at the rvalid edge
  task automatic rd(input logic [15:0] idx, input logic [7:0] d,
                    input logic [1:0] r = AEC_RESP_OKAY);
    @(posedge clk);
    araddr <= {idx, 2'h0};
    {arvalid, rready} <= 2'h3;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, {24'h0, d});
    chk({30'h0, rresp}, {30'h0, r});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // reset values, a hole in the map, a write to a read-only count
  task automatic t_reset();
    rd(`AEC_IDX_EDGE, 8'h00);
    rd(`AEC_IDX_CLKC, 8'h00);
    rd(`AEC_IDX_CSR, 8'h00);
    rd(16'hFF93, 8'h00, AEC_RESP_SLVERR);
    wr(16'hFF93, 8'hFF, AEC_RESP_SLVERR);
    wr(`AEC_IDX_LCNT, 8'h55);
    rd(`AEC_IDX_LCNT, 8'h00);
    rd(`AEC_IDX_UCNT, 8'h00);
  endtask
  // 300 falling edges chained: lower wraps once into upper
  task automatic t_chain();
    wr(`AEC_IDX_CSR, 8'h0F);
    aec_event_src_i.pulse(1'b0, 300, 100);
    wr(`AEC_IDX_CSR, 8'h03);
    aec_event_src_i.pulse(1'b0, 4, 100);
    rd(`AEC_IDX_LCNT, 8'h2C);
    rd(`AEC_IDX_UCNT, 8'h01);
    rd(`AEC_IDX_CSR, 8'h43);
  endtask
  // status from the wrap drives irq only when unmasked
  task automatic t_irq();
    rd(`AEC_IDX_ISTAT, 8'h01);
    chk({31'h0, irq}, 32'h0);
    wr(`AEC_IDX_IMASK, 8'h03);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(`AEC_IDX_ISTAT, 8'h01);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask
  // zero after a read of one clears the flag; release low holds clear
  task automatic t_clear();
    wr(`AEC_IDX_CSR, 8'h0C);
    aec_event_src_i.pulse(1'b0, 3, 100);
    wr(`AEC_IDX_CSR, 8'h00);
    rd(`AEC_IDX_CSR, 8'h00);
    rd(`AEC_IDX_LCNT, 8'h00);
    rd(`AEC_IDX_UCNT, 8'h00);
  endtask
  // split channels, slow lower pulses; upper wraps on its own pin
  task automatic t_split();
    wr(`AEC_IDX_CSR, 8'h1F);
    aec_event_src_i.pulse(1'b1, 257, 100);
    aec_event_src_i.pulse(1'b0, 2, 330);
    wr(`AEC_IDX_CSR, 8'h13);
    rd(`AEC_IDX_UCNT, 8'h01);
    rd(`AEC_IDX_LCNT, 8'h02);
    rd(`AEC_IDX_CSR, 8'h93);
    wr(`AEC_IDX_CSR, 8'h00);
  endtask
  // power save: counts go on through a wrap, flags stay
  task automatic t_psave();
    @(posedge clk);
    ps <= 1'b1;
    wr(`AEC_IDX_CSR, 8'h1F);
    aec_event_src_i.pulse(1'b0, 261, 100);
    wr(`AEC_IDX_CSR, 8'h13);
    ps <= 1'b0;
    rd(`AEC_IDX_LCNT, 8'h05);
    rd(`AEC_IDX_CSR, 8'h13);
    rd(`AEC_IDX_ISTAT, 8'h02);
  endtask
  // rising then both edges; pin edges while enable is low are lost
  task automatic t_modes();
    wr(`AEC_IDX_EDGE, 8'h10);
    rd(`AEC_IDX_EDGE, 8'h10);
    wr(`AEC_IDX_CSR, 8'h17);
    aec_event_src_i.pulse(1'b0, 3, 100);
    @(posedge clk);
    ce <= 1'b0;
    aec_event_src_i.pulse(1'b0, 2, 100);
    @(posedge clk);
    ce <= 1'b1;
    wr(`AEC_IDX_EDGE, 8'h20);
    aec_event_src_i.pulse(1'b0, 2, 100);
    wr(`AEC_IDX_CSR, 8'h13);
    rd(`AEC_IDX_LCNT, 8'h0C);
  endtask

  // verdict in one place
  task automatic finish_test();
    $display("checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // main sequence: 4-cycle reset, then scenarios in order
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, ps} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    ce = 1'b1;
    nrst = 1'b0;
    miscompares = 0;
    checked = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_chain();
    t_irq();
    t_clear();
    t_split();
    t_psave();
    t_modes();
    finish_test();
  end
  // watchdog: scenarios need about 180 us
  initial begin
    #600000;
    miscompares++;
    finish_test();
  end
endmodule
